// [axd_defs.svh]
// Offsets, field positions, reset values and timing counts of the axis command block
`ifndef AXD_DEFS_SVH
`define AXD_DEFS_SVH
`define AXD_AX_N 4
`define AXD_GP_N 14
`define AXD_A_CMD 8'h00
`define AXD_A_ARG 8'h04
`define AXD_A_STAT 8'h08
`define AXD_A_REPLY 8'h0c
`define AXD_A_SEL 8'h10
`define AXD_A_ACC 8'h14
`define AXD_A_VEL 8'h18
`define AXD_A_BASE 8'h1c
`define AXD_A_POS 8'h20
`define AXD_A_ENC 8'h24
`define AXD_A_SETTLE 8'h28
`define AXD_A_CFG 8'h2c
`define AXD_A_RATIO 8'h30
`define AXD_A_DIR 8'h34
`define AXD_A_SLOTS 8'h38
`define AXD_CF_AUTO 0
`define AXD_CF_SENSE 4
`define AXD_CF_ENC 8
`define AXD_CF_SERVO 12
`define AXD_CF_HOLD 16
`define AXD_CF_SLIP 20
`define AXD_CF_PROF 24
`define AXD_CF_ALLAX 26
`define AXD_ACC_RST 32'h00030d40
`define AXD_VEL_RST 32'h00004e20
`define AXD_DIR_RST 12'hf00
`define AXD_RATIO_RST 16'h0001
`define AXD_ACC_MAX 32'h3b9aca00
`define AXD_VEL_MAX 32'h000f4240
`define AXD_SETTLE_MAX 32'h000003e8
`define AXD_SLOTS_GO 16'h0003
`define AXD_LF 8'h0a
`define AXD_CR 8'h0d
`define AXD_MS_NS 1000000
`define AXD_CLK_NS 8
`endif

// [axd_pkg.sv]
// Types shared by the axis command block
`include "axd_defs.svh"
package axd_pkg;
   typedef enum logic [3:0] {
      AXD_OP_NOP = 4'h0, AXD_OP_SETTLE = 4'h1, AXD_OP_LOW = 4'h2, AXD_OP_HIGH = 4'h3,
      AXD_OP_STATE_Q = 4'h4, AXD_OP_DIR_Q = 4'h5, AXD_OP_RAMP = 4'h6, AXD_OP_TOP = 4'h7,
      AXD_OP_START = 4'h8, AXD_OP_PRESET = 4'h9, AXD_OP_WAIT = 4'ha
   } axd_op_t;
   typedef struct packed {
      logic [31:0] acc;
      logic [31:0] vel;
      logic [31:0] base;
      logic [31:0] pos;
   } axd_axis_t;
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [31:0] arg;
      logic err;
      logic [1:0] sel;
      logic [26:0] cfg;
      logic [15:0] ratio;
      logic [11:0] dir;
      logic [13:0] drv;
      logic [13:0] sync1;
      logic [13:0] sync2;
      logic [1:0] latch;
      logic [63:0] reply;
      logic [3:0] rcnt;
      logic [15:0] slots;
      logic [`AXD_AX_N-1:0][31:0] acc;
      logic [`AXD_AX_N-1:0][31:0] vel;
      logic [`AXD_AX_N-1:0][31:0] base;
      logic [`AXD_AX_N-1:0][31:0] pos;
      logic [`AXD_AX_N-1:0][31:0] enc;
      logic [`AXD_AX_N-1:0][9:0] settle;
      logic [`AXD_AX_N-1:0][9:0] ms;
      logic [`AXD_AX_N-1:0][16:0] sub;
      logic [`AXD_AX_N-1:0] run;
      logic [`AXD_AX_N-1:0] aux;
   } axd_st_t;
endpackage

// [axd_cmd_core.sv]
// Axis parameter, bit I/O and settling command block with Avalon-MM registers
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "axd_defs.svh"
module axd_cmd_core #(
   parameter int unsigned MS_CYCLES = `AXD_MS_NS / `AXD_CLK_NS
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [7:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [3:0] byteenable_in,
   input wire logic [31:0] writedata_in,
   output logic [31:0] readdata_out,
   output logic waitrequest_out,
   input wire logic [13:0] gpio_in,
   output logic [13:0] gpio_out,
   output logic [13:0] gpio_oe_n_out,
   input wire logic [`AXD_AX_N-1:0] move_start_in,
   input wire logic [`AXD_AX_N-1:0] move_done_in,
   input wire logic interp_we_in,
   input wire logic [1:0] interp_axis_in,
   input wire logic [31:0] interp_acc_in,
   input wire logic [31:0] interp_vel_in,
   output axd_pkg::axd_axis_t [`AXD_AX_N-1:0] axis_out,
   output logic [`AXD_AX_N-1:0] aux_out,
   output logic [`AXD_AX_N-1:0] pos_hold_out,
   output logic [`AXD_AX_N-1:0] slip_irq_en_out,
   output logic cmd_error_out
);
   localparam logic [16:0] SUB_LD = 17'(MS_CYCLES - 1);

   axd_pkg::axd_st_t st;
   axd_pkg::axd_st_t n;
   logic acc_wr;
   logic rd_go;
   logic cmd_go;
   axd_pkg::axd_op_t op;
   logic [1:0] ax;
   logic [31:0] argv;
   logic [3:0] bi;
   logic bi_ok;
   logic [13:0] dirv;
   logic [15:0] bits;

   function automatic logic [7:0] hx(input logic [3:0] d);
      hx = (d < 4'ha) ? 8'h30 + {4'h0, d} : 8'h37 + {4'h0, d};
   endfunction

   function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] w,
                                       input logic [3:0] be);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = w[8*i +: 8];
         end
      end
      mrg = r;
   endfunction

   // ******************************************
   // Bus decode
   // ******************************************
   // One wait cycle: read data is registered first, side effects hit at the release
   assign waitrequest_out = (read_in | write_in) & ~st.ack;
   assign acc_wr = write_in & st.ack;
   assign rd_go = read_in & st.ack;
   assign cmd_go = acc_wr && (address_in == `AXD_A_CMD);
   assign op = axd_pkg::axd_op_t'(writedata_in[3:0]);
   assign ax = writedata_in[5:4];
   assign argv = writedata_in[8] ? st.arg : 32'h0;
   assign bi = argv[3:0];
   assign bi_ok = argv < 32'h0000000e;
   assign dirv = {2'b11, st.dir};
   // Output lines read back the wire too, so an external short shows up
   assign bits = {2'b00, ~st.sync2 | {12'h0, st.latch}};

   assign readdata_out = st.rdata;
   assign gpio_out = st.drv;
   assign gpio_oe_n_out = ~dirv;
   assign aux_out = st.aux;
   assign cmd_error_out = st.err;
   assign pos_hold_out = st.cfg[`AXD_CF_HOLD +: 4];
   assign slip_irq_en_out = st.cfg[`AXD_CF_SLIP +: 4];

   // ******************************************
   // Axis parameters to the motion engine
   // ******************************************
   always_comb begin
      for (int a = 0; a < `AXD_AX_N; a++) begin
         axis_out[a].acc = st.acc[a];
         axis_out[a].vel = st.vel[a];
         // Step-in speed is dropped for shaped profiles without an error
         axis_out[a].base = (st.cfg[`AXD_CF_PROF +: 2] == 2'b00) ? st.base[a] : 32'h0;
         axis_out[a].pos = st.pos[a];
      end
   end

   // ******************************************
   // Next state
   // ******************************************
   always_comb begin
      n = st;
      n.ack = (read_in | write_in) & ~st.ack;
      n.sync1 = gpio_in;
      n.sync2 = st.sync1;
      if (!st.ack) begin
         case (address_in)
            `AXD_A_ARG: n.rdata = st.arg;
            `AXD_A_STAT: n.rdata = {30'h0, st.rcnt != 4'h0, st.err};
            `AXD_A_REPLY: n.rdata = {23'h0, st.rcnt != 4'h0, st.reply[63:56]};
            `AXD_A_SEL: n.rdata = {30'h0, st.sel};
            `AXD_A_ACC: n.rdata = st.acc[st.sel];
            `AXD_A_VEL: n.rdata = st.vel[st.sel];
            `AXD_A_BASE: n.rdata = st.base[st.sel];
            `AXD_A_POS: n.rdata = st.pos[st.sel];
            `AXD_A_ENC: n.rdata = st.enc[st.sel];
            `AXD_A_SETTLE: n.rdata = {22'h0, st.settle[st.sel]};
            `AXD_A_CFG: n.rdata = {5'h0, st.cfg};
            `AXD_A_RATIO: n.rdata = {16'h0, st.ratio};
            `AXD_A_DIR: n.rdata = {18'h0, dirv};
            `AXD_A_SLOTS: n.rdata = {16'h0, st.slots};
            default: n.rdata = 32'h0;
         endcase
      end
      if (rd_go && address_in == `AXD_A_REPLY && st.rcnt != 4'h0) begin
         n.reply = {st.reply[55:0], 8'h0};
         n.rcnt = st.rcnt - 4'h1;
      end
      if (acc_wr) begin
         case (address_in)
            `AXD_A_ARG: n.arg = mrg(st.arg, writedata_in, byteenable_in);
            `AXD_A_STAT: n.err = st.err & ~writedata_in[0];
            `AXD_A_SEL: n.sel = writedata_in[1:0];
            `AXD_A_CFG: n.cfg = 27'(mrg({5'h0, st.cfg}, writedata_in, byteenable_in));
            `AXD_A_RATIO: n.ratio = 16'(mrg({16'h0, st.ratio}, writedata_in, byteenable_in));
            `AXD_A_DIR: n.dir = 12'(mrg({20'h0, st.dir}, writedata_in, byteenable_in));
            `AXD_A_SLOTS: n.slots = 16'h0;
            default: ;
         endcase
      end
      if (cmd_go) begin
         case (op)
            axd_pkg::AXD_OP_SETTLE: begin
               if (st.cfg[`AXD_CF_ALLAX] || argv > `AXD_SETTLE_MAX) begin
                  n.err = 1'b1;
               end else begin
                  n.settle[ax] = argv[9:0];
               end
            end
            axd_pkg::AXD_OP_LOW, axd_pkg::AXD_OP_HIGH: begin
               if (bi_ok && dirv[bi]) begin
                  n.drv[bi] = (op == axd_pkg::AXD_OP_HIGH);
               end else begin
                  n.err = 1'b1;
               end
            end
            axd_pkg::AXD_OP_STATE_Q: begin
               n.reply = {`AXD_LF, `AXD_CR, hx(bits[15:12]), hx(bits[11:8]),
                          hx(bits[7:4]), hx(bits[3:0]), `AXD_LF, `AXD_CR};
               n.rcnt = 4'h8;
               n.latch = 2'b00;
            end
            axd_pkg::AXD_OP_DIR_Q: begin
               n.reply = {`AXD_LF, `AXD_CR, hx({2'b00, dirv[13:12]}), hx(dirv[11:8]),
                          hx(dirv[7:4]), hx(dirv[3:0]), `AXD_LF, `AXD_CR};
               n.rcnt = 4'h8;
            end
            axd_pkg::AXD_OP_RAMP: begin
               if (argv != 32'h0 && argv < `AXD_ACC_MAX) begin
                  n.acc[ax] = argv;
               end else begin
                  n.err = 1'b1;
               end
            end
            axd_pkg::AXD_OP_TOP: begin
               if (argv != 32'h0 && argv <= `AXD_VEL_MAX) begin
                  n.vel[ax] = argv;
               end else begin
                  n.err = 1'b1;
               end
            end
            axd_pkg::AXD_OP_START: begin
               if (argv != 32'h0 && argv < st.vel[ax]) begin
                  n.base[ax] = argv;
               end else begin
                  n.err = 1'b1;
               end
            end
            axd_pkg::AXD_OP_PRESET: begin
               n.pos[ax] = argv;
               if (st.cfg[`AXD_CF_ENC + ax]) begin
                  n.enc[ax] = argv;
                  n.pos[ax] = 32'($signed(argv) * $signed({16'h0, st.ratio}));
                  if (!st.cfg[`AXD_CF_SERVO + ax]) begin
                     n.cfg[`AXD_CF_HOLD + ax] = 1'b0;
                     n.cfg[`AXD_CF_SLIP + ax] = 1'b0;
                  end
               end
            end
            axd_pkg::AXD_OP_WAIT: begin
               if (writedata_in[8] && argv < 32'h2) begin
                  n.latch[argv[0]] = 1'b0;
               end
            end
            default: n.err = 1'b1;
         endcase
      end
      // Latch set comes last so a low line never loses to a clear
      n.latch = n.latch | ~st.sync2[1:0];
      if (interp_we_in) begin
         n.acc[interp_axis_in] = interp_acc_in;
         n.vel[interp_axis_in] = interp_vel_in;
      end
      for (int a = 0; a < `AXD_AX_N; a++) begin
         if (move_start_in[a] && st.settle[a] != 10'h0) begin
            n.slots = n.slots + `AXD_SLOTS_GO;
         end
         if (st.cfg[`AXD_CF_AUTO + a]) begin
            if (move_start_in[a]) begin
               n.aux[a] = ~st.cfg[`AXD_CF_SENSE + a];
               n.run[a] = 1'b0;
            end else if (move_done_in[a]) begin
               if (st.settle[a] == 10'h0) begin
                  n.aux[a] = st.cfg[`AXD_CF_SENSE + a];
               end else begin
                  n.run[a] = 1'b1;
                  n.ms[a] = st.settle[a];
                  n.sub[a] = SUB_LD;
               end
            end else if (st.run[a]) begin
               if (st.sub[a] != 17'h0) begin
                  n.sub[a] = st.sub[a] - 17'h1;
               end else if (st.ms[a] == 10'h1) begin
                  n.run[a] = 1'b0;
                  n.aux[a] = st.cfg[`AXD_CF_SENSE + a];
               end else begin
                  n.ms[a] = st.ms[a] - 10'h1;
                  n.sub[a] = SUB_LD;
               end
            end
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         st <= '0;
         st.acc <= {`AXD_AX_N{`AXD_ACC_RST}};
         st.vel <= {`AXD_AX_N{`AXD_VEL_RST}};
         st.dir <= `AXD_DIR_RST;
         st.drv <= '1;
         st.ratio <= `AXD_RATIO_RST;
         st.aux <= '1;
         st.sync1 <= '1;
         st.sync2 <= '1;
      end else begin
         st <= n;
      end
   end

   // ******************************************
   // Checks
   // ******************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   property p_settle;
      cmd_go && op == axd_pkg::AXD_OP_SETTLE && argv > `AXD_SETTLE_MAX
         |=> st.err && $stable(st.settle);
   endproperty
   a_settle: assert property (p_settle) else $error("settle range not enforced");
   property p_slots;
      move_start_in == 4'h1 && st.settle[0] != 10'h0 |=> st.slots == $past(st.slots) + 16'h3;
   endproperty
   a_slots: assert property (p_slots) else $error("slot cost wrong");
   property p_low;
      cmd_go && op == axd_pkg::AXD_OP_LOW && bi_ok && dirv[bi] |=> !gpio_out[$past(bi)];
   endproperty
   a_low: assert property (p_low) else $error("drive low failed");
   property p_in_line;
      cmd_go && op inside {axd_pkg::AXD_OP_LOW, axd_pkg::AXD_OP_HIGH} && bi_ok && !dirv[bi]
         |=> st.err && $stable(gpio_out);
   endproperty
   a_in_line: assert property (p_in_line) else $error("input line driven");
   property p_latch;
      !st.sync2[0] |=> st.latch[0];
   endproperty
   a_latch: assert property (p_latch) else $error("low on line 0 lost");
   property p_dir;
      cmd_go && op == axd_pkg::AXD_OP_DIR_Q |=> st.reply[47:40] == 8'h33 && st.rcnt == 4'h8;
   endproperty
   a_dir: assert property (p_dir) else $error("direction digit not 3");
   property p_acc;
      cmd_go && op == axd_pkg::AXD_OP_RAMP && argv == 32'h0 |=> st.err && $stable(st.acc);
   endproperty
   a_acc: assert property (p_acc) else $error("zero accel accepted");
   property p_vel;
      cmd_go && op == axd_pkg::AXD_OP_TOP && argv > `AXD_VEL_MAX |=> $stable(st.vel);
   endproperty
   a_vel: assert property (p_vel) else $error("speed limit not enforced");
   property p_base;
      cmd_go && op == axd_pkg::AXD_OP_START && argv >= st.vel[ax] |=> $stable(st.base);
   endproperty
   a_base: assert property (p_base) else $error("base not below peak");
   property p_rst;
      $rose(resetn_in) |-> st.acc[0] == `AXD_ACC_RST && st.vel[0] == `AXD_VEL_RST
         && st.base[0] == 32'h0 && gpio_out == 14'h3fff;
   endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   property p_preset;
      cmd_go && op == axd_pkg::AXD_OP_PRESET && !writedata_in[8] |=> st.pos[$past(ax)] == 32'h0;
   endproperty
   a_preset: assert property (p_preset) else $error("preset without arg not zero");
   c_query: cover property (cmd_go && op == axd_pkg::AXD_OP_STATE_Q ##[1:4] rd_go);
   c_settle: cover property (st.run[0] ##1 !st.run[0]);
   c_reject: cover property (cmd_go ##1 $rose(st.err));
endmodule
`default_nettype wire

// [axd_field_model.sv]
// Pin level and motion engine model facing the axis command block
`timescale 1ns/1ps
`default_nettype none
module axd_field_model #(
   parameter int MOVE_CYCLES = 6
) (
   input wire logic clk_in,
   input wire logic [13:0] gpio_level_in,
   input wire logic [13:0] gpio_oe_n_in,
   input wire logic [13:0] ext_low_in,
   input wire logic [3:0] move_start_in,
   output logic [13:0] gpio_out,
   output logic [3:0] move_done_out
);
   int cnt [4];
   // Lines nobody pulls low rest at the pull-up level
   always_comb begin
      for (int i = 0; i < 14; i++) begin
         gpio_out[i] = !gpio_oe_n_in[i] ? gpio_level_in[i] : !ext_low_in[i];
      end
   end
   always @(posedge clk_in) begin
      for (int i = 0; i < 4; i++) begin
         move_done_out[i] <= (cnt[i] == 1);
         if (move_start_in[i]) begin
            cnt[i] <= MOVE_CYCLES;
         end else if (cnt[i] > 0) begin
            cnt[i] <= cnt[i] - 1;
         end
      end
   end
endmodule
`default_nettype wire

// [test_axd_cmd_core.sv]
// Self-checking bench for the axis command block
`timescale 1ns/1ps
`default_nettype none
`include "axd_defs.svh"
module test_axd_cmd_core;
   // ****************
   // Signals
   // ****************
   localparam int MS = 10;
   localparam logic [3:0] T_OP [9] = '{4'h6, 4'h6, 4'h6, 4'h7, 4'h7, 4'h7, 4'h8, 4'h8, 4'h8};
   localparam logic [31:0] T_V [9] = '{32'h0, 32'h3b9aca00, 32'h3b9ac9ff, 32'h0,
      32'h000f4241, 32'h000f4240, 32'h000f4240, 32'h000f423f, 32'h0};
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [7:0] address_in = 8'h00;
   logic read_in = 1'b0;
   logic write_in = 1'b0;
   logic [31:0] writedata_in = 32'h0;
   logic [31:0] readdata_out;
   logic waitrequest_out;
   logic [13:0] gpio_in;
   logic [13:0] gpio_out;
   logic [13:0] gpio_oe_n_out;
   logic [13:0] ext_low = 14'h0;
   logic [3:0] move_start_in = 4'h0;
   logic [3:0] move_done;
   logic interp_we_in = 1'b0;
   logic [1:0] interp_axis_in = 2'h0;
   logic [31:0] interp_acc_in = 32'h0;
   logic [31:0] interp_vel_in = 32'h0;
   axd_pkg::axd_axis_t [`AXD_AX_N-1:0] axis_out;
   logic [3:0] aux_out;
   logic [3:0] pos_hold_out;
   logic [3:0] slip_irq_en_out;
   logic cmd_error_out;
   int miscompares = 0;
   int checks = 0;
   logic [31:0] seed = 32'h1923;
   logic [31:0] rd;
   logic [31:0] v;
   logic [31:0] ea = `AXD_ACC_RST;
   logic [31:0] ev = `AXD_VEL_RST;
   logic [31:0] eb = 32'h0;
   logic [3:0] op;
   logic ok;
   always #4 clk_in = ~clk_in;
   axd_cmd_core #(.MS_CYCLES(MS)) uut (.clk_in(clk_in), .resetn_in(resetn_in),
      .address_in(address_in), .read_in(read_in), .write_in(write_in),
      .byteenable_in(4'hf), .writedata_in(writedata_in), .readdata_out(readdata_out),
      .waitrequest_out(waitrequest_out), .gpio_in(gpio_in), .gpio_out(gpio_out),
      .gpio_oe_n_out(gpio_oe_n_out), .move_start_in(move_start_in),
      .move_done_in(move_done), .interp_we_in(interp_we_in),
      .interp_axis_in(interp_axis_in), .interp_acc_in(interp_acc_in),
      .interp_vel_in(interp_vel_in), .axis_out(axis_out), .aux_out(aux_out),
      .pos_hold_out(pos_hold_out), .slip_irq_en_out(slip_irq_en_out),
      .cmd_error_out(cmd_error_out));
   axd_field_model field (.clk_in(clk_in), .gpio_level_in(gpio_out),
      .gpio_oe_n_in(gpio_oe_n_out), .ext_low_in(ext_low), .move_start_in(move_start_in),
      .gpio_out(gpio_in), .move_done_out(move_done));
   // ****************
   // Helpers
   // ****************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] hexc(input logic [3:0] d);
      return (d < 4'ha) ? 8'h30 + {4'h0, d} : 8'h37 + {4'h0, d};
   endfunction
   function automatic logic legal(input logic [3:0] o, input logic [31:0] x);
      if (o == 4'h6) return x != 0 && x < 32'h3b9aca00;
      if (o == 4'h7) return x != 0 && x <= 32'h000f4240;
      return x != 0 && x < ev;
   endfunction
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      address_in <= a;
      writedata_in <= d;
      write_in <= wr;
      read_in <= !wr;
      @(posedge clk_in);
      chk("waitrequest", {31'h0, waitrequest_out}, 32'h1);
      while (waitrequest_out !== 1'b0) begin
         @(posedge clk_in);
      end
      rd = readdata_out;
      write_in <= 1'b0;
      read_in <= 1'b0;
   endtask
   task automatic cmd(input logic [3:0] o, input logic [1:0] ax, input logic g,
                      input logic [31:0] arg);
      bus(1'b1, `AXD_A_ARG, arg);
      bus(1'b1, `AXD_A_CMD, {23'h0, g, 2'b00, ax, o});
      @(posedge clk_in);
   endtask
   task automatic reply(input logic [15:0] val);
      logic [7:0] c [8];
      c = '{`AXD_LF, `AXD_CR, hexc(val[15:12]), hexc(val[11:8]), hexc(val[7:4]),
         hexc(val[3:0]), `AXD_LF, `AXD_CR};
      for (int k = 0; k < 8; k++) begin
         bus(1'b0, `AXD_A_REPLY, 32'h0);
         chk("reply", rd, {23'h0, 1'b1, c[k]});
      end
   endtask
   task automatic summarize();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Generous bound: the whole sequence needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk_in);
      miscompares++;
      summarize();
   end
   // ****************
   // Scenarios
   // ****************
   initial begin
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      for (int i = 0; i < 4; i++) begin
         chk("acc", axis_out[i].acc, `AXD_ACC_RST);
         chk("vel", axis_out[i].vel, `AXD_VEL_RST);
         chk("base", axis_out[i].base, 32'h0);
      end
      chk("gpio", {18'h0, gpio_out}, 32'h00003fff);
      chk("oe", {18'h0, gpio_oe_n_out}, 32'h000000ff);
      cmd(4'h5, 2'h0, 1'b0, 32'h0);
      reply(16'h3f00);
      for (int b = 8; b < 14; b++) cmd(4'h2, 2'h0, 1'b1, b);
      chk("gpio", {18'h0, gpio_out}, 32'h000000ff);
      ext_low <= 14'h0009;
      repeat (5) @(posedge clk_in);
      ext_low <= 14'h0008;
      repeat (5) @(posedge clk_in);
      cmd(4'h4, 2'h0, 1'b0, 32'h0);
      reply(16'h3f09);
      cmd(4'h4, 2'h0, 1'b0, 32'h0);
      reply(16'h3f08);
      ext_low <= 14'h000a;
      repeat (5) @(posedge clk_in);
      ext_low <= 14'h0008;
      repeat (5) @(posedge clk_in);
      cmd(4'ha, 2'h0, 1'b1, 32'h1);
      cmd(4'h4, 2'h0, 1'b0, 32'h0);
      reply(16'h3f08);
      for (int b = 8; b < 14; b++) cmd(4'h3, 2'h0, 1'b1, b);
      cmd(4'h2, 2'h0, 1'b1, 32'h3);
      chk("gpio", {18'h0, gpio_out}, 32'h00003fff);
      chk("err", {31'h0, cmd_error_out}, 32'h1);
      bus(1'b1, `AXD_A_STAT, 32'h1);
      seed = lfsr(seed);
      v = seed;
      bus(1'b1, `AXD_A_DIR, v);
      cmd(4'h5, 2'h0, 1'b0, 32'h0);
      reply({4'h3, v[11:0]});
      chk("oe", {18'h0, gpio_oe_n_out}, {18'h0, ~{2'b11, v[11:0]}});
      bus(1'b1, `AXD_A_DIR, 32'h00000f00);
      for (int k = 0; k < 25; k++) begin
         seed = lfsr(seed);
         op = (k < 9) ? T_OP[k] : 4'h6 + {2'h0, seed[1:0] % 2'h3};
         v = (k < 9) ? T_V[k] : seed & 32'h001fffff;
         ok = legal(op, v);
         cmd(op, 2'h1, 1'b1, v);
         chk("err", {31'h0, cmd_error_out}, {31'h0, !ok});
         if (ok && op == 4'h6) ea = v;
         if (ok && op == 4'h7) ev = v;
         if (ok && op == 4'h8) eb = v;
         chk("acc", axis_out[1].acc, ea);
         chk("vel", axis_out[1].vel, ev);
         chk("base", axis_out[1].base, eb);
         if (!ok) bus(1'b1, `AXD_A_STAT, 32'h1);
      end
      bus(1'b1, `AXD_A_SEL, 32'h1);
      bus(1'b0, `AXD_A_ACC, 32'h0);
      chk("acc reg", rd, ea);
      bus(1'b1, `AXD_A_CFG, 32'h01000000);
      @(posedge clk_in);
      chk("base", axis_out[1].base, 32'h0);
      @(posedge clk_in);
      interp_we_in <= 1'b1;
      interp_axis_in <= 2'h2;
      interp_acc_in <= seed;
      interp_vel_in <= ~seed;
      @(posedge clk_in);
      interp_we_in <= 1'b0;
      @(posedge clk_in);
      chk("acc", axis_out[2].acc, seed);
      chk("vel", axis_out[2].vel, ~seed);
      bus(1'b1, `AXD_A_CFG, 32'h00cc4c00);
      bus(1'b1, `AXD_A_RATIO, 32'h3);
      cmd(4'h9, 2'h0, 1'b0, seed);
      chk("pos", axis_out[0].pos, 32'h0);
      cmd(4'h9, 2'h0, 1'b1, seed);
      chk("pos", axis_out[0].pos, seed);
      cmd(4'h9, 2'h3, 1'b1, seed);
      chk("pos", axis_out[3].pos, seed * 32'h3);
      bus(1'b1, `AXD_A_SEL, 32'h3);
      bus(1'b0, `AXD_A_ENC, 32'h0);
      chk("enc", rd, seed);
      cmd(4'h9, 2'h2, 1'b1, seed);
      chk("hold", {28'h0, pos_hold_out}, 32'h4);
      chk("slip", {28'h0, slip_irq_en_out}, 32'h4);
      bus(1'b1, `AXD_A_CFG, 32'h04000001);
      cmd(4'h1, 2'h0, 1'b1, 32'h5);
      chk("err", {31'h0, cmd_error_out}, 32'h1);
      bus(1'b1, `AXD_A_STAT, 32'h1);
      bus(1'b1, `AXD_A_CFG, 32'h00000001);
      bus(1'b1, `AXD_A_SLOTS, 32'h0);
      cmd(4'h1, 2'h0, 1'b1, 32'h000003e9);
      chk("err", {31'h0, cmd_error_out}, 32'h1);
      bus(1'b1, `AXD_A_STAT, 32'h1);
      cmd(4'h1, 2'h0, 1'b1, 32'h3);
      move_start_in <= 4'h1;
      @(posedge clk_in);
      move_start_in <= 4'h0;
      for (int n = 0; n < 40 && move_done[0] !== 1'b1; n++) @(posedge clk_in);
      repeat (3 * MS - 1) @(posedge clk_in);
      chk("aux", {31'h0, aux_out[0]}, 32'h1);
      repeat (4) @(posedge clk_in);
      chk("aux", {31'h0, aux_out[0]}, 32'h0);
      bus(1'b0, `AXD_A_SLOTS, 32'h0);
      chk("slots", rd, 32'h3);
      summarize();
   end
endmodule
`default_nettype wire
